// *** logic/cfid_regs.v ***
// crypto feature id registers: wide and narrow read-only images
`timescale 1ns/1ns
`default_nettype none
`include "cfid_map.vh"
module cfid_regs #(
  parameter CRYPTO_PRESENT = 1
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // cluster strap
  input wire crypto_feature_disable,
  // system register access
  input wire sysreg_req,
  input wire sysreg_write,
  input wire [1:0] sysreg_op0,
  input wire [2:0] sysreg_op1,
  input wire [3:0] sysreg_crn,
  input wire [3:0] sysreg_crm,
  input wire [2:0] sysreg_op2,
  input wire [1:0] exc_level,
  output reg sysreg_ack,
  output reg sysreg_undef,
  output reg [63:0] sysreg_rdata,
  // external debug view
  output wire [63:0] debug_wide_isa_feature_id
);
  localparam ST_RESET = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state;
  reg crypto_off;
  reg [63:0] wide_isa_feature_id;
  reg [31:0] narrow_isa_feature_id;
  wire disable_sync;
  wire [63:0] narrow_image;
  wire crypto_on;
  wire hit_wide;
  wire hit_narrow;
  wire priv_ok;

  ////////////////////////////////////////////////////////////////////////
  // field placement and encoding match helpers

  function [63:0] put64;
    input [3:0] val;
    input integer lsb;
    begin
      put64 = {60'h000000000000000, val} << lsb;
    end
  endfunction

  function match;
    input [1:0] o0;
    input [2:0] o1;
    input [3:0] n;
    input [3:0] m;
    input [2:0] o2;
    begin
      match = (sysreg_op0 == o0) && (sysreg_op1 == o1) && (sysreg_crn == n) &&
              (sysreg_crm == m) && (sysreg_op2 == o2);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strap capture

  cfid_strap_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(crypto_feature_disable),
    .level_out(disable_sync)
  );

  // first cycle after release takes the synchronised strap, then holds
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_RESET;
      crypto_off <= 1'b0;
    end else begin
      case (state)
        ST_RESET: begin
          crypto_off <= disable_sync;
          state <= ST_RUN;
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end

  assign crypto_on = (CRYPTO_PRESENT != 0) && !crypto_off;

  ////////////////////////////////////////////////////////////////////////
  // register images; all other bits stay zero

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wide_isa_feature_id <= `CFID_WIDE_RESET;
      narrow_isa_feature_id <= `CFID_NARROW_RESET;
    end else begin
      wide_isa_feature_id <= put64(`CFID_VAL_DOT, `CFID_W_DOT_LSB) |
        put64(`CFID_VAL_RDM, `CFID_W_RDM_LSB) |
        put64(`CFID_VAL_ATOMIC, `CFID_W_ATOMIC_LSB) |
        put64(`CFID_VAL_CRC, `CFID_W_CRC_LSB) |
        put64(crypto_on ? `CFID_VAL_SHA2 : `CFID_VAL_NONE, `CFID_W_SHA2_LSB) |
        put64(crypto_on ? `CFID_VAL_SHA1 : `CFID_VAL_NONE, `CFID_W_SHA1_LSB) |
        put64(crypto_on ? `CFID_VAL_AES : `CFID_VAL_NONE, `CFID_W_AES_LSB);
      narrow_isa_feature_id <= narrow_image[31:0];
    end
  end

  // narrow fields all sit below bit 32; upper half dropped on purpose
  assign narrow_image = put64(`CFID_VAL_RDM, `CFID_N_RDM_LSB) |
    put64(`CFID_VAL_CRC, `CFID_N_CRC_LSB) |
    put64(crypto_on ? `CFID_VAL_SHA2 : `CFID_VAL_NONE, `CFID_N_SHA2_LSB) |
    put64(crypto_on ? `CFID_VAL_SHA1 : `CFID_VAL_NONE, `CFID_N_SHA1_LSB) |
    put64(crypto_on ? `CFID_VAL_AES : `CFID_VAL_NONE, `CFID_N_AES_LSB) |
    put64(`CFID_VAL_LOCAL_EVENT_SEND_FIELD, `CFID_N_LOCAL_EVENT_SEND_FIELD_LSB);

  assign debug_wide_isa_feature_id = wide_isa_feature_id;

  ////////////////////////////////////////////////////////////////////////
  // system register access

  assign hit_wide = match(`CFID_WIDE_OP0, `CFID_WIDE_OP1, `CFID_WIDE_CRN,
                          `CFID_WIDE_CRM, `CFID_WIDE_OP2);
  assign hit_narrow = match(`CFID_NARROW_OP0, `CFID_NARROW_OP1, `CFID_NARROW_CRN,
                            `CFID_NARROW_CRM, `CFID_NARROW_OP2);
  assign priv_ok = (exc_level != `CFID_EL0);

  // one-cycle answer; level zero, writes and unknown encodings trap
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sysreg_ack <= 1'b0;
      sysreg_undef <= 1'b0;
      sysreg_rdata <= 64'h0000000000000000;
    end else begin
      sysreg_ack <= sysreg_req;
      sysreg_undef <= 1'b0;
      sysreg_rdata <= 64'h0000000000000000;
      if (sysreg_req) begin
        if (!priv_ok || sysreg_write || !(hit_wide || hit_narrow)) begin
          sysreg_undef <= 1'b1;
        end else if (hit_wide) begin
          sysreg_rdata <= wide_isa_feature_id;
        end else begin
          sysreg_rdata <= {32'h00000000, narrow_isa_feature_id};
        end
      end
    end
  end
endmodule // cfid_regs
`default_nettype wire

// *** logic/cfid_strap_sync.v ***
// three-stage synchroniser for the crypto disable strap
`timescale 1ns/1ns
`default_nettype none
module cfid_strap_sync (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // pin and result
  input wire pin_in,
  output reg level_out
);
  reg stage_a;
  reg stage_b;
  reg stage_c;

  // stage_a only feeds stage_b; a change counts once b and c agree
  // no reset here: the strap must settle while the core is held in reset,
  // so rst is left unused on purpose
  always @(posedge core_clk) begin
    stage_a <= pin_in;
    stage_b <= stage_a;
    stage_c <= stage_b;
    if (stage_b == stage_c) begin
      level_out <= stage_c;
    end
  end
endmodule // cfid_strap_sync
`default_nettype wire

// *** pkg/cfid_map.vh ***
// register map and field constants for the crypto feature id registers
`ifndef CFID_MAP_VH
`define CFID_MAP_VH

// system register read encoding of the wide register
`define CFID_WIDE_OP0 2'h3
`define CFID_WIDE_OP1 3'h0
`define CFID_WIDE_CRN 4'h0
`define CFID_WIDE_CRM 4'h6
`define CFID_WIDE_OP2 3'h0

// system register read encoding of the narrow register
`define CFID_NARROW_OP0 2'h3
`define CFID_NARROW_OP1 3'h0
`define CFID_NARROW_CRN 4'h0
`define CFID_NARROW_CRM 4'h2
`define CFID_NARROW_OP2 3'h5

// wide register field positions (low bit)
`define CFID_W_DOT_LSB 44
`define CFID_W_RDM_LSB 28
`define CFID_W_ATOMIC_LSB 20
`define CFID_W_CRC_LSB 16
`define CFID_W_SHA2_LSB 12
`define CFID_W_SHA1_LSB 8
`define CFID_W_AES_LSB 4

// narrow register field positions (low bit)
`define CFID_N_RDM_LSB 24
`define CFID_N_CRC_LSB 16
`define CFID_N_SHA2_LSB 12
`define CFID_N_SHA1_LSB 8
`define CFID_N_AES_LSB 4
`define CFID_N_LOCAL_EVENT_SEND_FIELD_LSB 0

// field values
`define CFID_VAL_DOT 4'h1
`define CFID_VAL_RDM 4'h1
`define CFID_VAL_ATOMIC 4'h2
`define CFID_VAL_CRC 4'h1
`define CFID_VAL_SHA2 4'h1
`define CFID_VAL_SHA1 4'h1
`define CFID_VAL_AES 4'h2
`define CFID_VAL_LOCAL_EVENT_SEND_FIELD 4'h1
`define CFID_VAL_NONE 4'h0

// exception level codes
`define CFID_EL0 2'h0

// reset values of the held register images
`define CFID_WIDE_RESET 64'h0000000000000000
`define CFID_NARROW_RESET 32'h00000000

`endif

// *** testbench/cfid_regs_properties.sv ***
// port assertions for the crypto feature id registers
`timescale 1ns/1ns
`default_nettype none
module cfid_regs_props (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // access
  input wire crypto_feature_disable,
  input wire sysreg_req,
  input wire sysreg_write,
  input wire [1:0] sysreg_op0,
  input wire [2:0] sysreg_op1,
  input wire [3:0] sysreg_crn,
  input wire [3:0] sysreg_crm,
  input wire [2:0] sysreg_op2,
  input wire [1:0] exc_level,
  // answer
  input wire sysreg_ack,
  input wire sysreg_undef,
  input wire [63:0] sysreg_rdata,
  input wire [63:0] debug_wide_isa_feature_id
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire ok = sysreg_req && !sysreg_write && exc_level != 2'h0 && sysreg_op0 == 2'h3
    && sysreg_op1 == 3'h0 && sysreg_crn == 4'h0;
  a_ack_next: assert property (sysreg_req |=> sysreg_ack)
    else $error("ack missing");
  a_ack_cause: assert property (sysreg_ack |-> $past(sysreg_req))
    else $error("ack without request");
  a_low_level: assert property (sysreg_req && exc_level == 2'h0 |=> sysreg_undef)
    else $error("level zero read not refused");
  a_write_trap: assert property (sysreg_req && sysreg_write |=> sysreg_undef)
    else $error("write not refused");
  a_wide_read: assert property (ok && sysreg_crm == 4'h6 && sysreg_op2 == 3'h0 |=>
    !sysreg_undef && sysreg_rdata == debug_wide_isa_feature_id) else $error("wide read");
  a_narrow_read: assert property (ok && sysreg_crm == 4'h2 && sysreg_op2 == 3'h5 |=>
    !sysreg_undef && sysreg_rdata[63:16] == 48'h000000000101) else $error("narrow read");
  a_idle_zero: assert property (!sysreg_ack || sysreg_undef |-> sysreg_rdata == 64'h0)
    else $error("data outside read");
  a_debug_fixed: assert property (debug_wide_isa_feature_id != 64'h0 |->
    debug_wide_isa_feature_id[63:16] == 48'h000010001021) else $error("debug fields");
endmodule // cfid_regs_props
bind cfid_regs cfid_regs_props u_cfid_regs_props (.core_clk(core_clk), .rst(rst),
  .crypto_feature_disable(crypto_feature_disable), .sysreg_req(sysreg_req),
  .sysreg_write(sysreg_write), .sysreg_op0(sysreg_op0), .sysreg_op1(sysreg_op1),
  .sysreg_crn(sysreg_crn), .sysreg_crm(sysreg_crm), .sysreg_op2(sysreg_op2),
  .exc_level(exc_level), .sysreg_ack(sysreg_ack), .sysreg_undef(sysreg_undef),
  .sysreg_rdata(sysreg_rdata), .debug_wide_isa_feature_id(debug_wide_isa_feature_id));
`default_nettype wire

// *** testbench/test_cfid_regs.sv ***
// self-checking bench for the crypto feature id registers
`timescale 1ns/1ns
`default_nettype none
module test_cfid_regs;
  localparam [63:0] W_ON = 64'h0000100010211120;
  localparam [63:0] W_OFF = 64'h0000100010210000;
  localparam [63:0] N_ON = 64'h01011121;
  localparam [63:0] N_OFF = 64'h01010001;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg dis = 1'b0;
  reg req = 1'b0;
  reg wr = 1'b0;
  reg [1:0] el = 2'h0;
  reg [2:0] op2 = 3'h0;
  reg [3:0] crm = 4'h0;
  wire ack;
  wire undef;
  wire [63:0] rdata;
  wire [63:0] dbg;
  integer n_fail = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  always #5 core_clk = ~core_clk;
  cfid_regs #(.CRYPTO_PRESENT(1)) u_cfid_regs (.core_clk(core_clk), .rst(rst),
    .crypto_feature_disable(dis), .sysreg_req(req), .sysreg_write(wr), .sysreg_op0(2'h3),
    .sysreg_op1(3'h0), .sysreg_crn(4'h0), .sysreg_crm(crm), .sysreg_op2(op2),
    .exc_level(el), .sysreg_ack(ack), .sysreg_undef(undef), .sysreg_rdata(rdata),
    .debug_wide_isa_feature_id(dbg));
  ////////////////////////////////////////
  task end_of_test;
    begin
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [47:0] nm, input [63:0] e, input [63:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one access taken at the next edge, answer judged at the falling edge after it
  task acc(input w, input [1:0] l, input [3:0] m, input [2:0] o, input u, input [63:0] d);
    begin
      req = 1'b1;
      wr = w;
      el = l;
      crm = m;
      op2 = o;
      @(negedge core_clk);
      chk("ack", 64'h1, {63'h0, ack});
      chk("undef", {63'h0, u}, {63'h0, undef});
      chk("rdata", d, rdata);
    end
  endtask
  task idle;
    begin
      req = 1'b0;
      @(negedge core_clk);
    end
  endtask
  task rs(input v);
    begin
      rst = 1'b1;
      dis = v;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      repeat (3) @(negedge core_clk);
    end
  endtask
  task t_on;
    begin
      rs(1'b0);
      acc(1'b0, 2'h1, 4'h6, 3'h0, 1'b0, W_ON);
      acc(1'b0, 2'h2, 4'h2, 3'h5, 1'b0, N_ON);
      acc(1'b0, 2'h3, 4'h6, 3'h0, 1'b0, W_ON);
      idle;
      chk("debug", W_ON, dbg);
      $display("test on done");
    end
  endtask
  task t_refuse;
    begin
      acc(1'b0, 2'h0, 4'h6, 3'h0, 1'b1, 64'h0);
      acc(1'b0, 2'h0, 4'h2, 3'h5, 1'b1, 64'h0);
      acc(1'b1, 2'h1, 4'h6, 3'h0, 1'b1, 64'h0);
      acc(1'b0, 2'h1, 4'h6, 3'h5, 1'b1, 64'h0);
      acc(1'b0, 2'h1, 4'h2, 3'h0, 1'b1, 64'h0);
      idle;
      acc(1'b0, 2'h1, 4'h2, 3'h5, 1'b0, N_ON);
      idle;
      $display("test refuse done");
    end
  endtask
  task t_off;
    begin
      rs(1'b1);
      acc(1'b0, 2'h1, 4'h6, 3'h0, 1'b0, W_OFF);
      acc(1'b0, 2'h1, 4'h2, 3'h5, 1'b0, N_OFF);
      idle;
      dis = 1'b0;
      repeat (5) @(negedge core_clk);
      acc(1'b0, 2'h2, 4'h2, 3'h5, 1'b0, N_OFF);
      idle;
      chk("debug", W_OFF, dbg);
      $display("test off done");
    end
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  initial begin
    t_on;
    t_refuse;
    t_off;
    end_of_test;
  end
endmodule // test_cfid_regs
`default_nettype wire
